// File: common/smo_pkg.sv
`default_nettype none
package smo_pkg;

  // Bus geometry
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned NUM_CH = 2;

  // Register byte offsets
  localparam logic [5:0] OFS_CTRL      = 6'h00;
  localparam logic [5:0] OFS_DIV       = 6'h04;
  localparam logic [5:0] OFS_POS0      = 6'h08;
  localparam logic [5:0] OFS_WID0      = 6'h0c;
  localparam logic [5:0] OFS_LEN0      = 6'h10;
  localparam logic [5:0] OFS_CH_STRIDE = 6'h0c;
  localparam logic [5:0] OFS_STAT      = 6'h20;

  // Marker step sizes as counts of low zero bits
  localparam int unsigned POS_STEP_BITS = 5;
  localparam int unsigned WID_STEP_BITS = 4;

  // Values after reset and limits, in waveform points
  localparam int unsigned POS_RST = 32'h0000_0000;
  localparam int unsigned WID_RST = 32'h0000_0020;
  localparam int unsigned WID_MIN = 32'h0000_0020;
  localparam int unsigned WID_GAP = 32'h0000_0020;
  localparam int unsigned LEN_RST = 32'h0000_0400;
  localparam int unsigned LEN_MIN = 32'h0000_0040;

  // Sample clock divider, ratio kept as a one-hot value
  localparam int unsigned DIV_W   = 9;
  localparam logic [8:0]  DIV_RST = 9'h001;
  localparam logic [8:0]  DIV_MAX = 9'h100;

  // Sync shape and source selectors
  typedef enum logic {
    SHP_PULSE = 1'b0,
    SHP_WAVE  = 1'b1
  } smo_shape_t;

  typedef enum logic {
    SRC_FIRST_CHANNEL  = 1'b0,
    SRC_SECOND_CHANNEL = 1'b1
  } smo_src_t;

  // Control word, bit 0 first from the right
  typedef struct packed {
    logic       ext_clk;  // Bit 6: count on divided sample clock
    logic [1:0] user;     // Bits 5:4: channel plays arbitrary waveform
    smo_src_t   src;      // Bit 3: sync source channel
    smo_shape_t shape;    // Bit 2: sync shape
    logic       sync_en;  // Bit 1: sync output enable
    logic       out_en;   // Bit 0: main output enable
  } smo_ctrl_t;

  localparam int unsigned CTRL_W = $bits(smo_ctrl_t);
  localparam smo_ctrl_t CTRL_RST = '{
    ext_clk: 1'b0, user: 2'b00, src: SRC_FIRST_CHANNEL,
    shape: SHP_PULSE, sync_en: 1'b0, out_en: 1'b0};

  // Status word
  typedef struct packed {
    logic       sync;     // Bit 4: sync output level
    logic [1:0] active;   // Bits 3:2: channel inside a cycle
    logic [1:0] mark;     // Bits 1:0: per-channel marker level
  } smo_stat_t;

  // Generator states, Gray along idle, play, last
  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_PLAY = 2'b01,
    GEN_LAST = 2'b11
  } smo_gen_state_t;

  // Offset of a per-channel register
  function automatic logic [5:0] ch_ofs(input logic [5:0] base,
                                        input int unsigned c);
    return base + 6'(c * OFS_CH_STRIDE);
  endfunction

endpackage
`default_nettype wire

// File: hdl/smo_marker_gen.sv
`timescale 1ns/1ps
`default_nettype none
module smo_marker_gen
  import smo_pkg::*;
#(
  parameter int unsigned PT_W = 26  // Point counter width
) (
  input  wire logic            clock_i,
  input  wire logic            rst_n_i,
  input  wire logic            ce_i,
  input  wire logic            tick_i,    // One waveform point passes
  input  wire logic            run_i,     // Channel asked to play
  input  wire logic            user_i,    // Arbitrary waveform mode
  input  wire smo_shape_t      shape_i,
  input  wire logic [PT_W-1:0] len_i,
  input  wire logic [PT_W-1:0] pos_i,
  input  wire logic [PT_W-1:0] wid_i,
  output logic                 mark_o,    // Marker level, one point late
  output logic                 active_o   // Inside a waveform cycle
);

  smo_gen_state_t  state_reg;   // Play state
  logic [PT_W-1:0] cnt_reg;     // Point within current cycle
  logic [PT_W-1:0] eff_pos;     // Position in force
  logic [PT_W-1:0] eff_wid;     // Width in force
  logic            last_pt;     // Final point of the cycle
  logic            hit;         // Counter inside pulse window
  logic            step;        // Advance on this edge

  assign step     = ce_i & tick_i;
  assign last_pt  = (cnt_reg == len_i - PT_W'(1));
  assign active_o = (state_reg != GEN_IDLE);

  // Standard waveforms use the reset placement, user settings otherwise
  assign eff_pos = user_i ? pos_i : PT_W'(POS_RST);
  assign eff_wid = user_i ? wid_i : PT_W'(WID_RST);

  // Window test widened by one bit so pos plus width cannot wrap
  assign hit = (cnt_reg >= eff_pos) &&
               ({1'b0, cnt_reg} < {1'b0, eff_pos} + {1'b0, eff_wid});

  // Play state: a cycle once started always runs to its end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= GEN_IDLE;
    end else if (step) begin
      case (state_reg)
        GEN_IDLE: if (run_i) state_reg <= GEN_PLAY;
        GEN_PLAY: begin
          if (last_pt && !run_i) state_reg <= GEN_IDLE;
          else if (!run_i) state_reg <= GEN_LAST;
        end
        GEN_LAST: begin
          if (last_pt) state_reg <= run_i ? GEN_PLAY : GEN_IDLE;
          else if (run_i) state_reg <= GEN_PLAY;
        end
        default: state_reg <= GEN_IDLE;
      endcase
    end
  end

  // Point counter, cleared at each cycle start
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (step) begin
      if (state_reg == GEN_IDLE || last_pt) cnt_reg <= '0;
      else cnt_reg <= cnt_reg + PT_W'(1);
    end
  end

  // Marker level; wave shape ignores position and width
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mark_o <= 1'b0;
    end else if (step) begin
      if (state_reg == GEN_IDLE) mark_o <= 1'b0;
      else if (shape_i == SHP_WAVE) mark_o <= 1'b1;
      else mark_o <= hit;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  pulse_place_a: assert property (
    step && active_o && shape_i == SHP_PULSE && user_i && cnt_reg == pos_i
    |=> mark_o) else $error("marker missing at programmed position");

  wave_cycle_a: assert property (
    step && active_o && shape_i == SHP_WAVE |=> mark_o)
    else $error("wave marker low inside a cycle");

  wave_ignore_a: assert property (
    step && active_o && shape_i == SHP_WAVE && user_i &&
    cnt_reg < pos_i |=> mark_o)
    else $error("wave marker followed programmed position");

  idle_low_a: assert property (
    step && !active_o |=> !mark_o) else $error("marker high while idle");

endmodule
`default_nettype wire

// File: hdl/smo_top.sv
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Main output enable comes up off
// - Disabled output path carries no waveform
// - Output enable reads back one or zero
// - Sync shape pulse or wave-complete, pulse default
// - Pulse lasts at least sixteen sample clocks
// - Pulse width adjusts in sixteen-point steps
// - Pulse starts at programmed position
// - Wave-complete marker spans one whole cycle
// - Wave-complete mode ignores width and position
// - Position multiple of 32, bounded, resets zero
// - Width from 32 points, resets to 32
// - Divider powers of two up to 256
// - Sync follows selected channel, first default
// - Sync enable reads back, off after reset
// - Position and width act in arbitrary mode only
module smo_top
  import smo_pkg::*;
#(
  parameter int unsigned MEM_POINTS = 32000000,  // Waveform memory depth
  parameter int unsigned PT_W       = 26,        // Point counter width
  parameter int unsigned SMP_W      = 16         // Sample word width
) (
  input  wire logic                          clock_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          ce_i,
  input  wire logic [ADDR_W-1:0]             avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [DATA_W-1:0]             avs_writedata_i,
  output logic      [DATA_W-1:0]             avs_readdata_o,
  output logic                               avs_waitrequest_o,
  input  wire logic [NUM_CH-1:0]             run_i,
  input  wire logic [NUM_CH-1:0][SMP_W-1:0]  wave_i,
  output logic      [NUM_CH-1:0][SMP_W-1:0]  wave_o,
  output logic                               sync_o
);

  localparam int unsigned POS_MAX = MEM_POINTS - 32'd32;  // Last position

  smo_ctrl_t            ctrl_reg;                // Control word
  logic [DIV_W-1:0]     div_reg;                 // One-hot divide ratio
  logic [7:0]           div_cnt_reg;             // Divider phase
  logic [PT_W-1:0]      pos_reg [NUM_CH];        // Marker position
  logic [PT_W-1:0]      wid_reg [NUM_CH];        // Marker width
  logic [PT_W-1:0]      len_reg [NUM_CH];        // Segment length
  logic [NUM_CH-1:0]    mark;                    // Per-channel marker
  logic [NUM_CH-1:0]    active;                  // Per-channel activity
  logic [DATA_W-1:0]    rd_next;                 // Read mux output
  logic                 req;                     // Any bus request
  logic                 wr_go;                   // Write completes now
  logic                 tick;                    // One point passes
  logic                 sync_next;               // Gated selected marker
  logic [DATA_W-1:0]    wd;                      // Short name for data
  smo_stat_t            stat;                    // Status word

  assign wd    = avs_writedata_i;
  assign req   = avs_read_i | avs_write_i;
  assign wr_go = avs_write_i & ~avs_waitrequest_o;

  // Bus handshake: every access waits exactly one cycle.
  // The request edge loads read data, the next edge completes.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
    end
  end

  // Read data loaded one edge ahead so it stands when waitrequest drops
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= '0;
    end else if (ce_i && avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rd_next;
    end
  end

  // Status view of the block's own state
  assign stat = '{sync: sync_o, active: active, mark: mark};

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_next = '0;
    if (avs_address_i == OFS_CTRL) begin
      rd_next = DATA_W'(ctrl_reg);
    end else if (avs_address_i == OFS_DIV) begin
      rd_next = DATA_W'(div_reg);
    end else if (avs_address_i == OFS_STAT) begin
      rd_next = DATA_W'(stat);
    end
    for (int unsigned c = 0; c < NUM_CH; c++) begin
      if (avs_address_i == ch_ofs(OFS_POS0, c)) rd_next = DATA_W'(pos_reg[c]);
      if (avs_address_i == ch_ofs(OFS_WID0, c)) rd_next = DATA_W'(wid_reg[c]);
      if (avs_address_i == ch_ofs(OFS_LEN0, c)) rd_next = DATA_W'(len_reg[c]);
    end
  end

  // Control word; enables and shape come up in their safe state
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RST;
    end else if (ce_i && wr_go && avs_address_i == OFS_CTRL) begin
      ctrl_reg <= smo_ctrl_t'(wd[CTRL_W-1:0]);
    end
  end

  // Divider ratio; any value not a power of two up to 256 is dropped,
  // so the ratio never leaves a legal setting
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= DIV_RST;
    end else if (ce_i && wr_go && avs_address_i == OFS_DIV) begin
      if (wd != '0 && (wd & (wd - 32'd1)) == '0 &&
          wd <= DATA_W'(DIV_MAX)) begin
        div_reg <= wd[DIV_W-1:0];
      end
    end
  end

  // Divider phase; internal clock gives a point on every cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_reg <= '0;
    end else if (ce_i) begin
      if (tick) div_cnt_reg <= '0;
      else div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  assign tick = !ctrl_reg.ext_clk ||
                ({1'b0, div_cnt_reg} == div_reg - 9'h001);

  // Per-channel settings and marker generators
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam logic [5:0] A_POS = ch_ofs(OFS_POS0, c);
    localparam logic [5:0] A_WID = ch_ofs(OFS_WID0, c);
    localparam logic [5:0] A_LEN = ch_ofs(OFS_LEN0, c);
    logic upper_zero;  // No bits beyond the counter width

    assign upper_zero = (wd >> PT_W) == '0;

    // Position: multiple of 32 within memory, else write dropped
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        pos_reg[c] <= PT_W'(POS_RST);
      end else if (ce_i && wr_go && avs_address_i == A_POS) begin
        if (wd[POS_STEP_BITS-1:0] == '0 && wd <= POS_MAX &&
            upper_zero) begin
          pos_reg[c] <= wd[PT_W-1:0];
        end
      end
    end

    // Width: 16-point steps, at least 32, and 32 short of the segment.
    // The 32-point floor keeps a pulse over 16 sample clocks.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        wid_reg[c] <= PT_W'(WID_RST);
      end else if (ce_i && wr_go && avs_address_i == A_WID) begin
        if (wd[WID_STEP_BITS-1:0] == '0 && wd >= WID_MIN &&
            upper_zero &&
            wd <= DATA_W'(len_reg[c]) - WID_GAP) begin
          wid_reg[c] <= wd[PT_W-1:0];
        end
      end
    end

    // Segment length; short segments refused so width bounds hold
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        len_reg[c] <= PT_W'(LEN_RST);
      end else if (ce_i && wr_go && avs_address_i == A_LEN) begin
        if (wd >= LEN_MIN && upper_zero &&
            wd >= DATA_W'(wid_reg[c]) + WID_GAP) begin
          len_reg[c] <= wd[PT_W-1:0];
        end
      end
    end

    // Marker generator for this channel
    smo_marker_gen #(
      .PT_W (PT_W)
    ) u_gen (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_i),
      .ce_i     (ce_i),
      .tick_i   (tick),
      .run_i    (run_i[c]),
      .user_i   (ctrl_reg.user[c]),
      .shape_i  (ctrl_reg.shape),
      .len_i    (len_reg[c]),
      .pos_i    (pos_reg[c]),
      .wid_i    (wid_reg[c]),
      .mark_o   (mark[c]),
      .active_o (active[c])
    );

    // Main output gated; the pin stays driven, just at zero
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        wave_o[c] <= '0;
      end else if (ce_i) begin
        wave_o[c] <= ctrl_reg.out_en ? wave_i[c] : '0;
      end
    end

    pos_legal_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      pos_reg[c][POS_STEP_BITS-1:0] == '0 && 32'(pos_reg[c]) <= POS_MAX)
      else $error("marker position off its grid");

    wid_legal_a: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      wid_reg[c][WID_STEP_BITS-1:0] == '0 && 32'(wid_reg[c]) >= WID_MIN)
      else $error("marker width off its grid");
  end

  // Sync source select and enable
  assign sync_next = ctrl_reg.sync_en && mark[ctrl_reg.src];

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_o <= 1'b0;
    end else if (ce_i) begin
      sync_o <= sync_next;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  reset_off_a: assert property (
    $rose(rst_n_i) |-> !ctrl_reg.out_en && !ctrl_reg.sync_en &&
    ctrl_reg.shape == SHP_PULSE && ctrl_reg.src == SRC_FIRST_CHANNEL)
    else $error("enables or selectors not at reset values");

  out_gate_a: assert property (
    ce_i && !ctrl_reg.out_en |=> wave_o == '0)
    else $error("waveform passed while output disabled");

  out_readback_a: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_CTRL
    |-> avs_readdata_o[0] == ctrl_reg.out_en)
    else $error("output enable read back wrong");

  sync_readback_a: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_CTRL
    |-> avs_readdata_o[1] == ctrl_reg.sync_en)
    else $error("sync enable read back wrong");

  sync_off_a: assert property (
    ce_i && !ctrl_reg.sync_en |=> !sync_o)
    else $error("sync high while disabled");

  sync_source_a: assert property (
    ce_i && ctrl_reg.sync_en && ctrl_reg.src == SRC_SECOND_CHANNEL &&
    mark[1] && !mark[0] |=> sync_o)
    else $error("sync not following second channel");

  div_onehot_a: assert property (
    div_reg != '0 && (div_reg & (div_reg - 9'h001)) == '0)
    else $error("divider ratio not a power of two");

  bus_answer_a: assert property (
    req && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o)
    else $error("bus answer late");

  wave_pass_c: cover property (ce_i && ctrl_reg.out_en && wave_o != '0);
  pulse_sync_c: cover property (ctrl_reg.shape == SHP_PULSE && $rose(sync_o));
  wave_sync_c: cover property (ctrl_reg.shape == SHP_WAVE && $fell(sync_o));
  second_src_c: cover property (
    ctrl_reg.src == SRC_SECOND_CHANNEL && sync_o);

endmodule
`default_nettype wire

// File: tb/smo_sync_rx.sv
`timescale 1ns/1ps
`default_nettype none
// Equipment at the sync output: times the first marker after a start
module smo_sync_rx (
  input  wire logic clock_i,  // Sample clock
  input  wire logic rst_n_i,  // Async reset, active low
  input  wire logic start_i,  // Level, playback requested
  input  wire logic sync_i,   // Marker from the generator
  output var  int   rise_o,   // Cycles from start to first high, -1 if none
  output var  int   width_o   // High cycles of that first marker
);
  int   cnt;      // Cycles since start
  logic start_q;  // Start delayed for edge detection
  logic done;     // First marker has ended

  // Only listens, never drives, so it cannot mask a fault at the pin
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_q <= 1'b0;
      cnt     <= 0;
      rise_o  <= -1;
      width_o <= 0;
      done    <= 1'b0;
    end else begin
      start_q <= start_i;
      // New start clears the old measurement
      if (start_i && !start_q) begin
        cnt     <= 0;
        rise_o  <= -1;
        width_o <= 0;
        done    <= 1'b0;
      end else begin
        cnt <= cnt + 1;
        // Later markers are ignored, the first one is what matters
        if (sync_i && rise_o < 0) rise_o <= cnt;
        if (sync_i && !done) width_o <= width_o + 1;
        if (!sync_i && rise_o >= 0) done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import smo_pkg::*;
;
  localparam int MEM = 32000000;  // Memory depth in points

  logic                        clock_i;            // 200 MHz clock
  logic                        rst_n_i;            // Reset, active low
  logic                        ce_i;               // Clock enable
  logic [ADDR_W-1:0]           avs_address_i;      // Byte address
  logic                        avs_read_i;         // Read request
  logic                        avs_write_i;        // Write request
  logic [DATA_W-1:0]           avs_writedata_i;    // Write data
  logic [DATA_W-1:0]           avs_readdata_o;     // Read data
  logic                        avs_waitrequest_o;  // Slave stall
  logic [NUM_CH-1:0]           run_i;              // Play request
  logic [NUM_CH-1:0][15:0]     wave_i;             // Samples in
  logic [NUM_CH-1:0][15:0]     wave_o;             // Samples out
  logic                        sync_o;             // Marker pin
  int                          fail_count;         // Mismatches
  int                          comparisons;        // Compares made
  int                          rise;               // Measured start
  int                          wid;                // Measured width
  int                          d0;                 // Pipeline delay, pos 0
  // Register model, indexed by word address; 8 status, 9 unmapped
  int mdl[10] = '{0, 1, 0, 32, 1024, 0, 32, 1024, 0, 0};
  // Write table: word index, value; illegal values must be dropped
  int tw[$] = '{1, 3, 1, 512, 1, 256, 1, 1, 2, 33, 2, 31999968,
                2, 32000000, 2, 0, 3, 24, 3, 40, 3, 48, 3, 32,
                4, 32, 4, 128, 8, 5, 9, 7, 0, 1};

  smo_top #(.MEM_POINTS(MEM)) u_smo_top (
    .clock_i           (clock_i),
    .rst_n_i           (rst_n_i),
    .ce_i              (ce_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .run_i             (run_i),
    .wave_i            (wave_i),
    .wave_o            (wave_o),
    .sync_o            (sync_o)
  );

  smo_sync_rx u_smo_sync_rx (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .start_i (|run_i),
    .sync_i  (sync_o),
    .rise_o  (),
    .width_o ()
  );

  // Free-running clock, 5 ns period
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  // Fresh random samples each cycle so gating faults show up.
  // Seeded here, once, because each process draws from its own generator.
  initial begin
    void'($urandom(32'hb268));
    forever begin
      @(posedge clock_i);
      wave_i <= 32'($urandom);
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Report counts and the verdict, then stop
  task automatic complete_run();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One bus cycle; request held until waitrequest is seen low
  task automatic bus(input bit w, input int a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address_i   <= 6'(a * 4);
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (n >= 100) chk(32'h1, 32'h0);
    // Idle edge so the next request never lands in the same step
    @(posedge clock_i);
  endtask

  // Legality as the register rules define it
  function automatic bit ok(int a, int d);
    case (a)
      0:       return d < 128;
      1:       return d inside {1, 2, 4, 8, 16, 32, 64, 128, 256};
      2, 5:    return d % 32 == 0 && d <= MEM - 32;
      3, 6:    return d % 16 == 0 && d >= 32 && d <= mdl[a+1] - 32;
      4, 7:    return d >= 64 && d >= mdl[a-1] + 32;
      default: return 1'b0;
    endcase
  endfunction

  // Write through the bus and update the model when accepted
  task automatic wr(input int a, input int d);
    logic [31:0] q;
    bus(1'b1, a, 32'(d), q);
    if (ok(a, d)) mdl[a] = d;
  endtask

  // Read through the bus and compare with the model
  task automatic rdchk(input int a);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, 32'(mdl[a]));
  endtask

  // Output path follows input one cycle late, or stays zero
  task automatic gate();
    logic [31:0] pw;
    pw = wave_i;
    repeat (16) begin
      @(posedge clock_i);
      chk(wave_o, mdl[0][0] ? pw : 32'h0);
      pw = wave_i;
    end
  endtask

  // One playback on a channel, then read the receiver
  task automatic play(input int ch, output int r, output int w);
    run_i[ch] <= 1'b1;
    repeat (2) @(posedge clock_i);
    run_i <= '0;
    repeat (400) @(posedge clock_i);
    r = u_smo_sync_rx.rise_o;
    w = u_smo_sync_rx.width_o;
  endtask

  // Hang guard, well past the few thousand cycles the tests need
  initial begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    complete_run();
  end

  // Main sequence
  initial begin
    rst_n_i         = 1'b0;
    ce_i            = 1'b1;
    avs_address_i   = '0;
    avs_read_i      = 1'b0;
    avs_write_i     = 1'b0;
    avs_writedata_i = '0;
    run_i           = '0;
    wave_i          = '0;
    fail_count      = 0;
    comparisons     = 0;
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    for (int a = 0; a < 10; a++) rdchk(a);
    gate();
    $display("test reset values done");
    for (int i = 0; i < tw.size(); i += 2) begin
      wr(tw[i], tw[i+1]);
      rdchk(tw[i]);
    end
    gate();
    $display("test register access done");
    // Pulse mode, arbitrary waveform, sync on
    wr(0, 'h13);
    play(0, d0, wid);
    chk(wid, mdl[3]);
    wr(2, 64);
    wr(3, 48);
    play(0, rise, wid);
    chk(rise, d0 + mdl[2]);
    chk(wid, mdl[3]);
    $display("test pulse marker done");
    // Wave-complete spans the whole segment, position ignored
    wr(0, 'h17);
    play(0, rise, wid);
    chk(rise, d0);
    chk(wid, mdl[4]);
    // Without arbitrary mode the programmed marker has no effect
    wr(0, 'h03);
    play(0, rise, wid);
    chk(rise, d0);
    chk(wid, 32);
    $display("test marker shapes done");
    // Second channel as source, its own settings
    wr(7, 256);
    wr(6, 64);
    wr(5, 32);
    wr(0, 'h2b);
    play(1, rise, wid);
    chk(rise, d0 + mdl[5]);
    chk(wid, mdl[6]);
    play(0, rise, wid);
    chk(rise, -1);
    $display("test source select done");
    // Divided sample clock stretches the marker by the ratio
    wr(1, 2);
    wr(0, 'h53);
    play(0, rise, wid);
    chk(wid, mdl[3] * mdl[1]);
    // Sync disabled gives no marker at all
    wr(0, 'h11);
    play(0, rise, wid);
    chk(rise, -1);
    $display("test divider and disable done");
    complete_run();
  end
endmodule
`default_nettype wire
